// [inc/rsx_pkg.sv]
// constants and types for the rotate/subtract/skip/xor execution block
package rsx_pkg;
  localparam int DATA_W = 8;
  localparam int PADDR_W = 13;
  localparam int PWORD_W = 16;
  localparam int OP_W = 5;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONES = 8'hFF;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;
  localparam logic [PADDR_W-1:0] LAST_PAGE_BASE = 13'h1F00;
  localparam logic [PADDR_W-1:0] PAGE_MASK = 13'h1F00;
  localparam logic [1:0] DUMMY_CYCLES = 2'h1;

  // operation codes presented by the decoder
  typedef enum logic [OP_W-1:0] {
    OP_NOP          = 5'h00,
    OP_ROTL_ACC     = 5'h01,
    OP_ROTL_C       = 5'h02,
    OP_ROTL_C_ACC   = 5'h03,
    OP_ROTR_MEM     = 5'h04,
    OP_ROTR_ACC     = 5'h05,
    OP_ROTR_C       = 5'h06,
    OP_ROTR_C_ACC   = 5'h07,
    OP_SBC_ACC      = 5'h08,
    OP_SBC_MEM      = 5'h09,
    OP_SUB_ACC      = 5'h0A,
    OP_SUB_MEM      = 5'h0B,
    OP_SUB_IMM      = 5'h0C,
    OP_DEC_SKIP     = 5'h0D,
    OP_DEC_SKIP_ACC = 5'h0E,
    OP_INC_SKIP     = 5'h0F,
    OP_INC_SKIP_ACC = 5'h10,
    OP_SKIP_BIT_SET = 5'h11,
    OP_SKIP_ZERO    = 5'h12,
    OP_SKIP_ZERO_A  = 5'h13,
    OP_SKIP_BIT_CLR = 5'h14,
    OP_SET_BYTE     = 5'h15,
    OP_SET_BIT      = 5'h16,
    OP_SWAP_MEM     = 5'h17,
    OP_SWAP_ACC     = 5'h18,
    OP_TAB_CUR      = 5'h19,
    OP_TAB_LAST     = 5'h1A,
    OP_XOR_ACC      = 5'h1B,
    OP_XOR_MEM      = 5'h1C,
    OP_XOR_IMM      = 5'h1D
  } rsx_op_t;

  // execution sequencer
  // gray order: every step leaves or returns to idle with one bit flipping
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_DUMMY = 2'h1,
    ST_TABLE = 2'h2
  } rsx_state_t;
endpackage : rsx_pkg

// [hw/rsx_exec.sv]
// execution datapath for rotate, subtract, skip, set, swap, table read and xor
`timescale 1ns/100ps
module rsx_exec (
  // clock and reset
  input  wire logic                        REF_CLK_I,
  input  wire logic                        SYS_RST_I,
  // instruction issue from the decoder
  input  wire logic                        ISSUE_I,
  input  wire rsx_pkg::rsx_op_t            OP_I,
  input  wire logic [2:0]                  BIT_SEL_I,
  input  wire logic [rsx_pkg::DATA_W-1:0]  IMM_I,
  input  wire logic [rsx_pkg::DATA_W-1:0]  MEM_RDATA_I,
  // options and table pointers
  input  wire logic                        HIGH_PTR_EN_I,
  input  wire logic [rsx_pkg::DATA_W-1:0]  TBL_PTR_LOW_I,
  input  wire logic [rsx_pkg::DATA_W-1:0]  TBL_PTR_HIGH_I,
  input  wire logic [rsx_pkg::PADDR_W-1:0] PC_I,
  // program memory table port
  output logic                             PROG_RD_O,
  output logic [rsx_pkg::PADDR_W-1:0]      PROG_ADDR_O,
  input  wire logic [rsx_pkg::PWORD_W-1:0] PROG_DATA_I,
  // results
  output logic                             MEM_WE_O,
  output logic [rsx_pkg::DATA_W-1:0]       MEM_WDATA_O,
  output logic [rsx_pkg::DATA_W-1:0]       ACC_O,
  output logic [rsx_pkg::DATA_W-1:0]       TBL_RESULT_HIGH_O,
  output logic                             CARRY_O,
  output logic                             ZERO_O,
  output logic                             SIGNED_WRAP_O,
  output logic                             HALF_CARRY_O,
  output logic                             SKIP_O,
  output logic                             BUSY_O
);
  import rsx_pkg::*;

  rsx_state_t state;
  rsx_state_t next_state;
  logic [DATA_W-1:0] acc;
  logic              cy;
  logic              zf;
  logic              ov;
  logic              hc;
  logic [DATA_W-1:0] tbl_hi;

  // combinational results of the current issue
  logic [DATA_W-1:0] next_res;
  logic              res_to_acc;
  logic              res_to_mem;
  logic              upd_carry_rot;
  logic              upd_arith;
  logic              upd_zero;
  logic              next_cy;
  logic              next_ov;
  logic              next_hc;
  logic              skip_cond;
  logic              is_skip;

  // subtraction acc - b - borrow with flag outputs
  function automatic logic [DATA_W+2:0] sub_flags(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                                  input logic borrow);
    logic [DATA_W:0]   full;
    logic [4:0]        low;
    logic              ovf;
    full = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, borrow};
    low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow};
    ovf  = (a[7] ^ b[7]) & (a[7] ^ full[7]);
    // bits: carry(no borrow), overflow, half carry (no nibble borrow), result
    return {~full[DATA_W], ovf, ~low[4], full[DATA_W-1:0]};
  endfunction : sub_flags

  function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] sel);
    return BYTE_ONE << sel;
  endfunction : bit_mask

  logic [DATA_W+2:0] sub_out;
  logic [DATA_W-1:0] sub_b;
  logic              sub_borrow;
  logic              accept;
  assign accept = ISSUE_I && (state == ST_IDLE);
  assign sub_b = (OP_I == OP_SUB_IMM) ? IMM_I : MEM_RDATA_I;
  // borrow is the complement of carry only for the with-borrow forms
  assign sub_borrow = (OP_I == OP_SBC_ACC || OP_I == OP_SBC_MEM) ? ~cy : 1'b0;
  assign sub_out = sub_flags(acc, sub_b, sub_borrow);

  // operation decode and result selection
  always_comb begin
    next_res      = BYTE_ZERO;
    res_to_acc    = 1'b0;
    res_to_mem    = 1'b0;
    upd_carry_rot = 1'b0;
    upd_arith     = 1'b0;
    upd_zero      = 1'b0;
    next_cy       = cy;
    next_ov       = ov;
    next_hc       = hc;
    skip_cond     = 1'b0;
    is_skip       = 1'b0;
    unique case (OP_I)
      OP_ROTL_ACC: begin
        next_res = {MEM_RDATA_I[6:0], MEM_RDATA_I[7]};
        res_to_acc = 1'b1;
      end
      OP_ROTL_C, OP_ROTL_C_ACC: begin
        next_res = {MEM_RDATA_I[6:0], cy};
        next_cy = MEM_RDATA_I[7];
        upd_carry_rot = 1'b1;
        res_to_acc = (OP_I == OP_ROTL_C_ACC);
        res_to_mem = (OP_I == OP_ROTL_C);
      end
      OP_ROTR_MEM, OP_ROTR_ACC: begin
        next_res = {MEM_RDATA_I[0], MEM_RDATA_I[7:1]};
        res_to_acc = (OP_I == OP_ROTR_ACC);
        res_to_mem = (OP_I == OP_ROTR_MEM);
      end
      OP_ROTR_C, OP_ROTR_C_ACC: begin
        next_res = {cy, MEM_RDATA_I[7:1]};
        next_cy = MEM_RDATA_I[0];
        upd_carry_rot = 1'b1;
        res_to_acc = (OP_I == OP_ROTR_C_ACC);
        res_to_mem = (OP_I == OP_ROTR_C);
      end
      OP_SBC_ACC, OP_SBC_MEM, OP_SUB_ACC, OP_SUB_MEM, OP_SUB_IMM: begin
        next_res = sub_out[DATA_W-1:0];
        next_cy = sub_out[DATA_W+2];
        next_ov = sub_out[DATA_W+1];
        next_hc = sub_out[DATA_W];
        upd_arith = 1'b1;
        upd_zero = 1'b1;
        res_to_mem = (OP_I == OP_SBC_MEM || OP_I == OP_SUB_MEM);
        res_to_acc = ~res_to_mem;
      end
      OP_DEC_SKIP, OP_DEC_SKIP_ACC: begin
        next_res = MEM_RDATA_I - BYTE_ONE;
        is_skip = 1'b1;
        skip_cond = (next_res == BYTE_ZERO);
        res_to_acc = (OP_I == OP_DEC_SKIP_ACC);
        res_to_mem = (OP_I == OP_DEC_SKIP);
      end
      OP_INC_SKIP, OP_INC_SKIP_ACC: begin
        next_res = MEM_RDATA_I + BYTE_ONE;
        is_skip = 1'b1;
        skip_cond = (next_res == BYTE_ZERO);
        res_to_acc = (OP_I == OP_INC_SKIP_ACC);
        res_to_mem = (OP_I == OP_INC_SKIP);
      end
      OP_SKIP_BIT_SET: begin
        is_skip = 1'b1;
        skip_cond = (MEM_RDATA_I & bit_mask(BIT_SEL_I)) != BYTE_ZERO;
      end
      OP_SKIP_ZERO, OP_SKIP_ZERO_A: begin
        next_res = MEM_RDATA_I;
        is_skip = 1'b1;
        skip_cond = (MEM_RDATA_I == BYTE_ZERO);
        res_to_acc = (OP_I == OP_SKIP_ZERO_A);
      end
      OP_SKIP_BIT_CLR: begin
        is_skip = 1'b1;
        skip_cond = (MEM_RDATA_I & bit_mask(BIT_SEL_I)) == BYTE_ZERO;
      end
      OP_SET_BYTE: begin
        next_res = BYTE_ONES;
        res_to_mem = 1'b1;
      end
      OP_SET_BIT: begin
        next_res = MEM_RDATA_I | bit_mask(BIT_SEL_I);
        res_to_mem = 1'b1;
      end
      OP_SWAP_MEM, OP_SWAP_ACC: begin
        next_res = {MEM_RDATA_I[3:0], MEM_RDATA_I[7:4]};
        res_to_acc = (OP_I == OP_SWAP_ACC);
        res_to_mem = (OP_I == OP_SWAP_MEM);
      end
      OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM: begin
        next_res = acc ^ ((OP_I == OP_XOR_IMM) ? IMM_I : MEM_RDATA_I);
        upd_zero = 1'b1;
        res_to_mem = (OP_I == OP_XOR_MEM);
        res_to_acc = ~res_to_mem;
      end
      default: begin
        // nop and table reads produce nothing in the issue cycle
        next_res = BYTE_ZERO;
      end
    endcase
  end

  // sequencer: skips insert a dummy cycle, table reads wait for program data
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (ISSUE_I && is_skip) begin
          next_state = ST_DUMMY;
        end else if (ISSUE_I && (OP_I == OP_TAB_CUR || OP_I == OP_TAB_LAST)) begin
          next_state = ST_TABLE;
        end
      end
      ST_DUMMY: next_state = ST_IDLE;
      ST_TABLE: next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) state <= ST_IDLE;
    else state <= next_state;
  end

  // accumulator
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) acc <= BYTE_ZERO;
    else if (accept && res_to_acc) acc <= next_res;
  end

  // carry: rotates through carry and subtractions touch it
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) cy <= 1'b0;
    else if (accept && (upd_carry_rot || upd_arith)) cy <= next_cy;
  end

  // overflow and half carry only on subtraction
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      ov <= 1'b0;
      hc <= 1'b0;
    end else if (accept && upd_arith) begin
      ov <= next_ov;
      hc <= next_hc;
    end
  end

  // zero flag from the eight-bit result
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) zf <= 1'b0;
    else if (accept && upd_zero) zf <= (next_res == BYTE_ZERO);
  end

  // memory write port, registered so data is stable for a full cycle
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      MEM_WE_O    <= 1'b0;
      MEM_WDATA_O <= BYTE_ZERO;
    end else if (state == ST_TABLE) begin
      MEM_WE_O    <= 1'b1;
      MEM_WDATA_O <= PROG_DATA_I[DATA_W-1:0];
    end else begin
      MEM_WE_O    <= accept && res_to_mem;
      MEM_WDATA_O <= next_res;
    end
  end

  // skip request pulses in the dummy cycle following the decision
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) SKIP_O <= 1'b0;
    else SKIP_O <= accept && is_skip && skip_cond;
  end

  // program address: high pointer option widens the current-page read
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) begin
      PROG_RD_O   <= 1'b0;
      PROG_ADDR_O <= '0;
    end else begin
      PROG_RD_O <= accept && (OP_I == OP_TAB_CUR || OP_I == OP_TAB_LAST);
      if (accept && OP_I == OP_TAB_LAST)
        PROG_ADDR_O <= LAST_PAGE_BASE | {5'h00, TBL_PTR_LOW_I};
      else if (accept && OP_I == OP_TAB_CUR && HIGH_PTR_EN_I)
        PROG_ADDR_O <= {TBL_PTR_HIGH_I[PADDR_W-DATA_W-1:0], TBL_PTR_LOW_I};
      else if (accept && OP_I == OP_TAB_CUR)
        PROG_ADDR_O <= (PC_I & PAGE_MASK) | {5'h00, TBL_PTR_LOW_I};
    end
  end

  // high byte of the table word
  always_ff @(posedge REF_CLK_I) begin
    if (SYS_RST_I) tbl_hi <= BYTE_ZERO;
    else if (state == ST_TABLE) tbl_hi <= PROG_DATA_I[PWORD_W-1:DATA_W];
  end

  assign ACC_O             = acc;
  assign CARRY_O           = cy;
  assign ZERO_O            = zf;
  assign SIGNED_WRAP_O     = ov;
  assign HALF_CARRY_O      = hc;
  assign TBL_RESULT_HIGH_O = tbl_hi;
  assign BUSY_O            = (state != ST_IDLE);

  // checks
  property p_rotl_acc;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_ROTL_ACC) |=> (acc == {$past(MEM_RDATA_I[6:0]), $past(MEM_RDATA_I[7])}) && $stable(cy);
  endproperty
  a_rotl_acc: assert property (p_rotl_acc) else $error("rotate left to acc wrong");

  property p_rotl_c;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_ROTL_C) |=> MEM_WE_O && MEM_WDATA_O == {$past(MEM_RDATA_I[6:0]), $past(cy)}
      && cy == $past(MEM_RDATA_I[7]);
  endproperty
  a_rotl_c: assert property (p_rotl_c) else $error("rotate left through carry wrong");

  property p_rotr_c_acc;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_ROTR_C_ACC) |=> !MEM_WE_O && acc == {$past(cy), $past(MEM_RDATA_I[7:1])}
      && cy == $past(MEM_RDATA_I[0]);
  endproperty
  a_rotr_c_acc: assert property (p_rotr_c_acc) else $error("rotate right through carry to acc wrong");

  property p_sub_carry;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_SUB_ACC) |=> cy == ($past(acc) >= $past(MEM_RDATA_I));
  endproperty
  a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

  property p_sbc_mem;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_SBC_MEM) |=> MEM_WE_O
      && MEM_WDATA_O == 8'($past(acc) - $past(MEM_RDATA_I) - {7'h00, ~$past(cy)}) && $stable(acc);
  endproperty
  a_sbc_mem: assert property (p_sbc_mem) else $error("borrow subtract to memory wrong");

  sequence s_skip_issue;
    accept && is_skip;
  endsequence
  sequence s_dummy;
    BUSY_O ##1 !BUSY_O;
  endsequence
  property p_skip_two_cycles;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    s_skip_issue |=> s_dummy;
  endproperty
  a_skip_two_cycles: assert property (p_skip_two_cycles) else $error("skip not two cycles");

  property p_skip_bit_clr;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_SKIP_BIT_CLR) |=> SKIP_O == ((($past(MEM_RDATA_I) >> $past(BIT_SEL_I)) & BYTE_ONE) == BYTE_ZERO)
      && $stable(cy) && $stable(zf);
  endproperty
  a_skip_bit_clr: assert property (p_skip_bit_clr) else $error("bit clear skip wrong");

  property p_xor_zero;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_XOR_ACC) |=> zf == (acc == BYTE_ZERO) && $stable(cy) && $stable(ov);
  endproperty
  a_xor_zero: assert property (p_xor_zero) else $error("xor zero flag wrong");

  property p_tab_last;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_TAB_LAST) |=> PROG_RD_O && PROG_ADDR_O[PADDR_W-1:DATA_W] == LAST_PAGE_BASE[PADDR_W-1:DATA_W]
      ##1 MEM_WE_O;
  endproperty
  a_tab_last: assert property (p_tab_last) else $error("last page table read wrong");

  // immediate subtract lands in acc only, zero flag tracks the new acc
  property p_sub_imm;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_SUB_IMM) |=> acc == 8'($past(acc) - $past(IMM_I)) && zf == (acc == BYTE_ZERO)
      && !MEM_WE_O;
  endproperty
  a_sub_imm: assert property (p_sub_imm) else $error("immediate subtract wrong");

  // set byte writes all ones and leaves acc and carry alone
  property p_set_byte;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_SET_BYTE) |=> MEM_WE_O && MEM_WDATA_O == BYTE_ONES && $stable(acc) && $stable(cy);
  endproperty
  a_set_byte: assert property (p_set_byte) else $error("set byte wrong");

  // nibble swap into acc, memory untouched, carry and zero flags hold
  property p_swap_acc;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_SWAP_ACC) |=> acc == {$past(MEM_RDATA_I[3:0]), $past(MEM_RDATA_I[7:4])}
      && !MEM_WE_O && $stable(cy) && $stable(zf);
  endproperty
  a_swap_acc: assert property (p_swap_acc) else $error("nibble swap to acc wrong");

  // high pointer option: address built from both pointers, not the pc page
  property p_tab_high;
    @(posedge REF_CLK_I) disable iff (SYS_RST_I)
    (accept && OP_I == OP_TAB_CUR && HIGH_PTR_EN_I) |=> PROG_RD_O
      && PROG_ADDR_O == {$past(TBL_PTR_HIGH_I[PADDR_W-DATA_W-1:0]), $past(TBL_PTR_LOW_I)};
  endproperty
  a_tab_high: assert property (p_tab_high) else $error("high pointer table address wrong");
endmodule : rsx_exec

// [verification/tb_rsx_exec.sv]
// self-checking bench for the rotate/subtract/skip/xor execution block
`timescale 1ns/100ps
module tb_rsx_exec import rsx_pkg::*;;
  // stimulus and observed signals
  logic                ref_clk     = 1'b0;
  logic                sys_rst     = 1'b1;
  logic                issue       = 1'b0;
  rsx_op_t             op          = OP_NOP;
  logic [2:0]          bit_sel     = 3'h0;
  logic [DATA_W-1:0]   imm         = 8'h00;
  logic [DATA_W-1:0]   mem_rdata   = 8'h00;
  logic                high_ptr_en = 1'b0;
  logic [DATA_W-1:0]   tbl_ptr_low = 8'h00;
  logic [DATA_W-1:0]   tbl_ptr_high = 8'h00;
  logic [PADDR_W-1:0]  pc          = 13'h0000;
  logic [PWORD_W-1:0]  prog_data   = 16'h0000;
  logic                prog_rd;
  logic [PADDR_W-1:0]  prog_addr;
  logic                mem_we;
  logic [DATA_W-1:0]   mem_wdata;
  logic [DATA_W-1:0]   acc;
  logic [DATA_W-1:0]   tbl_result_high;
  logic                carry;
  logic                zero;
  logic                signed_wrap;
  logic                half_carry;
  logic                skip;
  logic                busy;
  // expected state kept by the bench
  logic [7:0]          e_acc = 8'h00;
  logic                e_c   = 1'b0;
  logic                e_z   = 1'b0;
  logic                e_ov  = 1'b0;
  logic                e_ac  = 1'b0;
  logic                e_we;
  logic [7:0]          e_wd;
  logic                e_skip;
  logic                e_busy;
  int                  error_cnt  = 0;
  int                  n_compared = 0;
  logic [7:0]          vals [7] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'hFF, 8'h96, 8'h5A};

  // 40 MHz core clock
  always #12.5 ref_clk = ~ref_clk;

  rsx_exec uut (
    .REF_CLK_I         (ref_clk),
    .SYS_RST_I         (sys_rst),
    .ISSUE_I           (issue),
    .OP_I              (op),
    .BIT_SEL_I         (bit_sel),
    .IMM_I             (imm),
    .MEM_RDATA_I       (mem_rdata),
    .HIGH_PTR_EN_I     (high_ptr_en),
    .TBL_PTR_LOW_I     (tbl_ptr_low),
    .TBL_PTR_HIGH_I    (tbl_ptr_high),
    .PC_I              (pc),
    .PROG_RD_O         (prog_rd),
    .PROG_ADDR_O       (prog_addr),
    .PROG_DATA_I       (prog_data),
    .MEM_WE_O          (mem_we),
    .MEM_WDATA_O       (mem_wdata),
    .ACC_O             (acc),
    .TBL_RESULT_HIGH_O (tbl_result_high),
    .CARRY_O           (carry),
    .ZERO_O            (zero),
    .SIGNED_WRAP_O     (signed_wrap),
    .HALF_CARRY_O      (half_carry),
    .SKIP_O            (skip),
    .BUSY_O            (busy)
  );

  // single comparison point, case equality so unknowns never match
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // reference subtraction: {carry, half carry, overflow, result}, carry means no borrow
  function automatic logic [10:0] subf(input logic [7:0] a, input logic [7:0] b, input logic br);
    logic [8:0] t;
    logic [4:0] l;
    t = {1'b0, a} - {1'b0, b} - {8'h00, br};
    l = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, br};
    subf = {~t[8], ~l[4], (a[7] ^ b[7]) & (t[7] ^ a[7]), t[7:0]};
  endfunction : subf

  // reference model; dst 1 is acc, 2 is memory; fl 1 carry, 2 subtract, 3 xor
  task automatic predict(input rsx_op_t o, input logic [7:0] m, input logic [7:0] i, input logic [2:0] b);
    logic [1:0]  dst;
    logic [1:0]  fl;
    logic        nc;
    logic [7:0]  r;
    logic [10:0] s;
    {dst, fl, e_busy, e_skip, nc, r, s} = {2'd0, 2'd0, 1'b0, 1'b0, e_c, 8'h00, 11'h000};
    case (o)
      OP_ROTL_ACC:     {dst, r} = {2'd1, m[6:0], m[7]};
      OP_ROTL_C:       {dst, fl, nc, r} = {2'd2, 2'd1, m[7], m[6:0], e_c};
      OP_ROTL_C_ACC:   {dst, fl, nc, r} = {2'd1, 2'd1, m[7], m[6:0], e_c};
      OP_ROTR_MEM:     {dst, r} = {2'd2, m[0], m[7:1]};
      OP_ROTR_ACC:     {dst, r} = {2'd1, m[0], m[7:1]};
      OP_ROTR_C:       {dst, fl, nc, r} = {2'd2, 2'd1, m[0], e_c, m[7:1]};
      OP_ROTR_C_ACC:   {dst, fl, nc, r} = {2'd1, 2'd1, m[0], e_c, m[7:1]};
      OP_SBC_ACC:      {dst, fl, s} = {2'd1, 2'd2, subf(e_acc, m, ~e_c)};
      OP_SBC_MEM:      {dst, fl, s} = {2'd2, 2'd2, subf(e_acc, m, ~e_c)};
      OP_SUB_ACC:      {dst, fl, s} = {2'd1, 2'd2, subf(e_acc, m, 1'b0)};
      OP_SUB_MEM:      {dst, fl, s} = {2'd2, 2'd2, subf(e_acc, m, 1'b0)};
      OP_SUB_IMM:      {dst, fl, s} = {2'd1, 2'd2, subf(e_acc, i, 1'b0)};
      OP_DEC_SKIP:     {dst, e_busy, e_skip, r} = {2'd2, 1'b1, m == 8'h01, m - 8'h01};
      OP_DEC_SKIP_ACC: {dst, e_busy, e_skip, r} = {2'd1, 1'b1, m == 8'h01, m - 8'h01};
      OP_INC_SKIP:     {dst, e_busy, e_skip, r} = {2'd2, 1'b1, m == 8'hFF, m + 8'h01};
      OP_INC_SKIP_ACC: {dst, e_busy, e_skip, r} = {2'd1, 1'b1, m == 8'hFF, m + 8'h01};
      OP_SKIP_BIT_SET: {e_busy, e_skip} = {1'b1, m[b]};
      OP_SKIP_ZERO:    {e_busy, e_skip} = {1'b1, m == 8'h00};
      OP_SKIP_ZERO_A:  {dst, e_busy, e_skip, r} = {2'd1, 1'b1, m == 8'h00, m};
      OP_SKIP_BIT_CLR: {e_busy, e_skip} = {1'b1, ~m[b]};
      OP_SET_BYTE:     {dst, r} = {2'd2, 8'hFF};
      OP_SET_BIT:      {dst, r} = {2'd2, m | (8'h01 << b)};
      OP_SWAP_MEM:     {dst, r} = {2'd2, m[3:0], m[7:4]};
      OP_SWAP_ACC:     {dst, r} = {2'd1, m[3:0], m[7:4]};
      OP_XOR_ACC:      {dst, fl, r} = {2'd1, 2'd3, e_acc ^ m};
      OP_XOR_MEM:      {dst, fl, r} = {2'd2, 2'd3, e_acc ^ m};
      OP_XOR_IMM:      {dst, fl, r} = {2'd1, 2'd3, e_acc ^ i};
      default:         dst = 2'd0;
    endcase
    // subtract results carry all four flags
    if (fl == 2'd2) begin
      {nc, e_ac, e_ov, r} = s;
    end
    e_c = nc;
    if (fl[1]) begin
      e_z = (r == 8'h00);
    end
    if (dst == 2'd1) begin
      e_acc = r;
    end
    e_we = (dst == 2'd2);
    e_wd = r;
  endtask : predict

  // compare acc, flags, skip, busy and the write port 1 ns after the edge that takes the issue
  task automatic observe();
    chk(acc, e_acc);
    chk(carry, e_c);
    chk(zero, e_z);
    chk(signed_wrap, e_ov);
    chk(half_carry, e_ac);
    chk(skip, e_skip);
    chk(busy, e_busy);
    chk(mem_we, e_we);
    if (e_we) begin
      chk(mem_wdata, e_wd);
    end
  endtask : observe

  // one request, then an idle cycle that also covers any dummy cycle
  task automatic step(input rsx_op_t o, input logic [7:0] m, input logic [7:0] i, input logic [2:0] b);
    predict(o, m, i, b);
    issue <= 1'b1;
    op <= o;
    mem_rdata <= m;
    imm <= i;
    bit_sel <= b;
    @(posedge ref_clk);
    issue <= 1'b0;
    #1 observe();
    @(posedge ref_clk);
  endtask : step

  // two single-cycle requests back to back, second one sees the first one's flags
  task automatic pair(input rsx_op_t o1, input logic [7:0] m1, input rsx_op_t o2, input logic [7:0] m2);
    predict(o1, m1, m1, 3'h0);
    issue <= 1'b1;
    op <= o1;
    mem_rdata <= m1;
    imm <= m1;
    @(posedge ref_clk);
    op <= o2;
    mem_rdata <= m2;
    imm <= m2;
    #1 observe();
    predict(o2, m2, m2, 3'h0);
    @(posedge ref_clk);
    issue <= 1'b0;
    #1 observe();
    @(posedge ref_clk);
  endtask : pair

  // table read: fetch request, then word split into memory byte and high result
  task automatic tab(input rsx_op_t o, input logic hen, input logic [12:0] p, input logic [7:0] lo,
                     input logic [7:0] hi, input logic [15:0] w, input logic [12:0] ea);
    issue <= 1'b1;
    op <= o;
    high_ptr_en <= hen;
    pc <= p;
    tbl_ptr_low <= lo;
    tbl_ptr_high <= hi;
    @(posedge ref_clk);
    issue <= 1'b0;
    prog_data <= w;
    #1 chk(prog_rd, 1'b1);
    chk(prog_addr, ea);
    chk(busy, 1'b1);
    @(posedge ref_clk);
    #1 chk(mem_we, 1'b1);
    chk(mem_wdata, w[7:0]);
    chk(tbl_result_high, w[15:8]);
    chk(carry, e_c);
    chk(acc, e_acc);
    @(posedge ref_clk);
  endtask : tab

  // verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results

  // watchdog sized well above the 500 cycles the sequence needs
  initial begin
    repeat (8000) @(posedge ref_clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 chk(acc, 8'h00);
    chk(busy, 1'b0);
    chk(mem_we, 1'b0);
    @(posedge ref_clk);
    // every code except the two table reads, unlisted ones included, over boundary operands
    for (int k = 0; k < 32; k++) begin
      if (k == 25 || k == 26) continue;
      foreach (vals[j]) step(rsx_op_t'(k[4:0]), vals[j], vals[j] ^ 8'h3C, 3'(j));
    end
    // every bit position for the bit forms
    for (int b = 0; b < 8; b++) begin
      step(OP_SKIP_BIT_SET, 8'hA5, 8'h00, 3'(b));
      step(OP_SKIP_BIT_CLR, 8'hA5, 8'h00, 3'(b));
      step(OP_SET_BIT, 8'h00, 8'h00, 3'(b));
    end
    // zero, negative and borrow-chained subtraction, with carry feeding the next op
    step(OP_SKIP_ZERO_A, 8'h80, 8'h00, 3'h0);
    step(OP_SUB_IMM, 8'h00, 8'h80, 3'h0);
    step(OP_SUB_IMM, 8'h00, 8'h01, 3'h0);
    pair(OP_SBC_ACC, 8'h7F, OP_SBC_MEM, 8'h80);
    pair(OP_SUB_ACC, 8'h10, OP_ROTL_C_ACC, 8'h81);
    pair(OP_XOR_IMM, 8'h0F, OP_XOR_ACC, 8'hF0);
    // request held through the dummy cycle is refused
    predict(OP_SKIP_ZERO_A, 8'h05, 8'h00, 3'h0);
    issue <= 1'b1;
    op <= OP_SKIP_ZERO_A;
    mem_rdata <= 8'h05;
    @(posedge ref_clk);
    op <= OP_SET_BYTE;
    #1 observe();
    @(posedge ref_clk);
    issue <= 1'b0;
    #1 chk(mem_we, 1'b0);
    @(posedge ref_clk);
    // table reads: current page, high pointer option, last page
    tab(OP_TAB_CUR, 1'b0, 13'h0A37, 8'h5C, 8'hE3, 16'hBEEF, {5'h0A, 8'h5C});
    tab(OP_TAB_CUR, 1'b1, 13'h0A37, 8'h5C, 8'hE3, 16'h1234, {5'h03, 8'h5C});
    tab(OP_TAB_LAST, 1'b1, 13'h0A37, 8'hC1, 8'hE3, 16'h80FE, LAST_PAGE_BASE | 13'h00C1);
    results();
  end
endmodule : tb_rsx_exec
